/* File: inc/host_port_defines.svh */
// Constants of the host strobe and wait port: bus style codes, pin levels,
// reset values and the width of the synchronised pin group.
// Assumes the host bus style straps are static while the port is in use.
//
// Notes on behaviour
// - Generic style: write strobe is active low, data taken on its rising edge.
// - Enable-clock style: write pin selects direction, high reads, low writes.
// - Data-strobe style: write pin is read-not-write, high reads, low writes.
// - Bus cycles are answered only while the active-low chip select is low.
// - Generic style: hold output driven low during a transfer to insert waits.
// - Generic style: hold driven inactive at completion, then released.
// - Data-strobe style: acknowledge driven high during a transfer to force waits.
// - Data-strobe style: acknowledge driven inactive at completion, then released.
// - Indirect addressing: hold or acknowledge output serves as host handshake.
// - Generic style: data output buffers enabled only while read strobe is low.
// - Enable-clock style: read pin is an active-high enable clock.
// - Data-strobe style: read pin is an active-low lower byte strobe.
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Bus style codes on the two straps
// ----------------------------------------------------------------
`define STYLE_GENERIC 2'h0
`define STYLE_ENABLE_CLOCK 2'h1
`define STYLE_DATA_STROBE 2'h2
`define STYLE_UNUSED 2'h3

// ----------------------------------------------------------------
// Hold / acknowledge pin levels
// ----------------------------------------------------------------
`define GEN_HOLD_ACTIVE 1'b0
`define GEN_HOLD_DONE 1'b1
`define DS_ACK_ACTIVE 1'b1
`define DS_ACK_DONE 1'b0

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define DATA_W 8
`define SYNC_W 13
`define SYNC_RST 13'h1f07
`define DATA_RST 8'h00

`endif

/* File: inc/host_port_pkg.sv */
// Types of the host strobe and wait port.
// Assumes host_port_defines.svh is on the include path.
`include "host_port_defines.svh"

package host_port_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_DONE = 2'b10
	} port_state_e;

	typedef logic [`DATA_W-1:0] byte_t;

	typedef struct packed {
		port_state_e st;
		logic is_read;
		logic hold_out;
		logic hold_oe;
		byte_t dout;
		logic dout_oe;
		byte_t wr_data;
		logic wr_valid;
		logic rd_req;
	} port_state_s;

endpackage

/* File: inc/pin_sync_if.sv */
// Carrier for the synchronised host pins between the synchroniser and the
// port logic. Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

interface pin_sync_if;
	logic cs_n;
	logic wr_pin;
	logic rd_pin;
	logic [1:0] style;
	logic [`DATA_W-1:0] data;

	modport producer (output cs_n, wr_pin, rd_pin, style, data);
	modport consumer (input cs_n, wr_pin, rd_pin, style, data);
endinterface

`default_nettype wire

/* File: hw/host_pin_sync.sv */
// Two-stage synchroniser for every host pin entering the clock domain.
// Assumes the pins are asynchronous to clk and the straps are static.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

module host_pin_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [`SYNC_W-1:0] pins_raw,
	pin_sync_if.producer sync
);
	logic [`SYNC_W-1:0] stage1_q;
	logic [`SYNC_W-1:0] stage2_q;
	localparam logic [`SYNC_W-1:0] SYNC_INIT = `SYNC_RST;

	// ----------------------------------------------------------------
	// Per-bit double flop; first stage feeds only the second
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					stage1_q[i] <= SYNC_INIT[i];
					stage2_q[i] <= SYNC_INIT[i];
				end else begin
					stage1_q[i] <= pins_raw[i];
					stage2_q[i] <= stage1_q[i];
				end
			end
		end
	endgenerate

	assign sync.data = stage2_q[7:0];
	assign sync.cs_n = stage2_q[8];
	assign sync.wr_pin = stage2_q[9];
	assign sync.rd_pin = stage2_q[10];
	assign sync.style = stage2_q[12:11];
endmodule

`default_nettype wire

/* File: hw/host_strobe_port.sv */
// Host strobe decoding, wait/acknowledge pin and data buffer control.
// Assumes a core on clk that accepts writes and answers reads by handshake;
// host strobes are asynchronous and pass the synchroniser first.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

module host_strobe_port (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic wr_pin,
	input wire logic rd_pin,
	input wire logic [1:0] bus_style_select,
	input wire logic [`DATA_W-1:0] data_in,
	output logic [`DATA_W-1:0] data_out,
	output logic data_oe,
	output logic transfer_acknowledge,
	output logic transfer_acknowledge_oe,
	output logic [`DATA_W-1:0] core_wr_data,
	output logic core_wr_valid,
	input wire logic core_wr_ready,
	output logic core_rd_req,
	input wire logic core_rd_valid,
	input wire host_port_pkg::byte_t core_rd_data
);
	import host_port_pkg::*;

	pin_sync_if sync ();
	port_state_s s_q;
	port_state_s s_d;
	logic sel;
	logic rd_dir;
	logic generic;
	logic ds_style;
	logic hold_used;
	logic hold_wait_lvl;
	logic hold_done_lvl;
	logic core_done;
	logic gen_rd_oe;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	host_pin_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pins_raw({bus_style_select, rd_pin, wr_pin, cs_n, data_in}),
		.sync(sync.producer)
	);

	// ----------------------------------------------------------------
	// Strobe decode per bus style
	// ----------------------------------------------------------------
	always_comb begin
		generic = 1'b0;
		ds_style = 1'b0;
		case (sync.style)
			`STYLE_GENERIC: begin
				generic = 1'b1;
			end
			`STYLE_DATA_STROBE: begin
				ds_style = 1'b1;
			end
			default: begin
				generic = 1'b0;
				ds_style = 1'b0;
			end
		endcase
	end

	// Enable-clock style leaves the pin floating
	assign hold_used = generic || ds_style;

	// ----------------------------------------------------------------
	// Hold pin levels per bus style
	// ----------------------------------------------------------------
	always_comb begin
		hold_wait_lvl = `GEN_HOLD_ACTIVE;
		hold_done_lvl = `GEN_HOLD_DONE;
		case (sync.style)
			`STYLE_GENERIC: begin
				hold_wait_lvl = `GEN_HOLD_ACTIVE;
				hold_done_lvl = `GEN_HOLD_DONE;
			end
			`STYLE_DATA_STROBE: begin
				hold_wait_lvl = `DS_ACK_ACTIVE;
				hold_done_lvl = `DS_ACK_DONE;
			end
			default: begin
				// Pin stays released here, level is moot
				hold_wait_lvl = `GEN_HOLD_ACTIVE;
				hold_done_lvl = `GEN_HOLD_DONE;
			end
		endcase
	end

	always_comb begin
		sel = 1'b0;
		rd_dir = 1'b0;
		case (sync.style)
			`STYLE_GENERIC: begin
				sel = !sync.rd_pin || !sync.wr_pin;
				rd_dir = !sync.rd_pin;
			end
			`STYLE_ENABLE_CLOCK: begin
				sel = sync.rd_pin;
				rd_dir = sync.wr_pin;
			end
			`STYLE_DATA_STROBE: begin
				sel = !sync.rd_pin;
				rd_dir = sync.wr_pin;
			end
			default: begin
				sel = 1'b0;
				rd_dir = 1'b0;
			end
		endcase
		// Unselected device ignores every strobe
		sel = sel && !sync.cs_n;
	end

	// ----------------------------------------------------------------
	// Core answer and generic read buffer
	// ----------------------------------------------------------------
	always_comb begin
		core_done = 1'b0;
		gen_rd_oe = 1'b0;
		if (s_q.is_read) begin
			core_done = core_rd_valid;
		end else begin
			core_done = core_wr_ready;
		end
		// Buffer follows the live strobe, not the latched state
		if (generic && s_q.is_read) begin
			gen_rd_oe = !sync.rd_pin && !sync.cs_n;
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.wr_valid = 1'b0;
		s_d.rd_req = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				s_d.hold_oe = 1'b0;
				s_d.dout_oe = 1'b0;
				if (sel) begin
					s_d.st = ST_BUSY;
					s_d.is_read = rd_dir;
					s_d.rd_req = rd_dir;
					// Generic writes take data later, on the strobe's rise
					s_d.wr_data = sync.data;
					// Hold asserted for the whole pending transfer
					s_d.hold_oe = hold_used;
					s_d.hold_out = hold_wait_lvl;
				end
			end
			ST_BUSY: begin
				if (!sel) begin
					// Host gave up early; drop everything
					s_d.st = ST_IDLE;
					s_d.hold_oe = 1'b0;
				end else if (core_done) begin
					s_d.st = ST_DONE;
					s_d.hold_out = hold_done_lvl;
					if (s_q.is_read) begin
						s_d.dout = core_rd_data;
						s_d.dout_oe = 1'b1;
					end else begin
						// Generic writes wait for the strobe's rise
						s_d.wr_valid = !generic;
					end
				end
			end
			ST_DONE: begin
				if (generic && s_q.is_read) begin
					s_d.dout_oe = gen_rd_oe;
				end
				if (!sel) begin
					s_d.st = ST_IDLE;
					s_d.dout_oe = 1'b0;
					// Release after the transfer ends
					s_d.hold_oe = 1'b0;
					if (generic && !s_q.is_read) begin
						s_d.wr_valid = 1'b1;
						s_d.wr_data = sync.data;
					end
				end
			end
			default: begin
				s_d.st = ST_IDLE;
				s_d.hold_oe = 1'b0;
				s_d.dout_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{
				st: ST_IDLE,
				is_read: 1'b0,
				hold_out: `GEN_HOLD_DONE,
				hold_oe: 1'b0,
				dout: `DATA_RST,
				dout_oe: 1'b0,
				wr_data: `DATA_RST,
				wr_valid: 1'b0,
				rd_req: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign data_out = s_q.dout;
	assign data_oe = s_q.dout_oe;
	assign transfer_acknowledge = s_q.hold_out;
	assign transfer_acknowledge_oe = s_q.hold_oe;
	assign core_wr_data = s_q.wr_data;
	assign core_wr_valid = s_q.wr_valid;
	assign core_rd_req = s_q.rd_req;
endmodule

`default_nettype wire

/* File: verification/host_strobe_port_checker.sv */
// Pin and handshake assertions for the host strobe port.
// Assumes one clock domain; bound to host_strobe_port.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

module host_strobe_port_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic wr_pin,
	input wire logic rd_pin,
	input wire logic [1:0] bus_style_select,
	input wire logic data_oe,
	input wire logic transfer_acknowledge,
	input wire logic transfer_acknowledge_oe,
	input wire logic core_wr_valid,
	input wire logic core_rd_req
);
	import host_port_pkg::*;
	logic gen, ds, ec;
	assign gen = bus_style_select == `STYLE_GENERIC;
	assign ds = bus_style_select == `STYLE_DATA_STROBE;
	assign ec = bus_style_select == `STYLE_ENABLE_CLOCK;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Wait phases must not be dropped directly
	// ----------------------------------------
	sequence s_gen_wait;
		gen && transfer_acknowledge_oe && !transfer_acknowledge;
	endsequence
	sequence s_ds_wait;
		ds && transfer_acknowledge_oe && transfer_acknowledge;
	endsequence
	property p_cs_gate;
		cs_n [*5] |-> !transfer_acknowledge_oe && !data_oe;
	endproperty
	property p_ec_float;
		ec |-> !transfer_acknowledge_oe;
	endproperty
	property p_gen_act;
		gen && $rose(transfer_acknowledge_oe) |-> !transfer_acknowledge;
	endproperty
	property p_ds_act;
		ds && $rose(transfer_acknowledge_oe) |-> transfer_acknowledge;
	endproperty
	property p_gen_hold;
		s_gen_wait |=> transfer_acknowledge_oe;
	endproperty
	property p_ds_hold;
		s_ds_wait |=> transfer_acknowledge_oe;
	endproperty
	property p_gen_rd_oe;
		gen && rd_pin [*4] |-> !data_oe;
	endproperty
	property p_gen_wr_edge;
		gen && core_wr_valid |-> wr_pin && $past(wr_pin);
	endproperty
	property p_rd_dir;
		core_rd_req |-> wr_pin && !cs_n && (gen || rd_pin == ec);
	endproperty
	a_cs_gate: assert property (p_cs_gate)
		else $error("access answered without chip select");
	a_ec_float: assert property (p_ec_float)
		else $error("hold pin driven in enable-clock style");
	a_gen_act: assert property (p_gen_act)
		else $error("generic hold not low when driven");
	a_ds_act: assert property (p_ds_act)
		else $error("acknowledge not high when driven");
	a_gen_hold: assert property (p_gen_hold)
		else $error("generic hold released before done");
	a_ds_hold: assert property (p_ds_hold)
		else $error("acknowledge released before done");
	a_gen_rd_oe: assert property (p_gen_rd_oe)
		else $error("data driven without read strobe");
	a_gen_wr_edge: assert property (p_gen_wr_edge)
		else $error("write issued before strobe rose");
	a_rd_dir: assert property (p_rd_dir)
		else $error("read issued with wrong pin levels");
endmodule

bind host_strobe_port host_strobe_port_checker host_strobe_port_checker_i (
	.clk, .sys_rst, .cs_n, .wr_pin, .rd_pin, .bus_style_select, .data_oe,
	.transfer_acknowledge, .transfer_acknowledge_oe, .core_wr_valid,
	.core_rd_req);
`default_nettype wire

/* File: verification/host_bus_model.sv */
// Host processor model for the parallel strobe bus.
// Assumes the straps are stable for the whole access.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

module host_bus_model (
	input wire logic clk,
	input wire logic [1:0] bus_style_select,
	input wire logic transfer_acknowledge,
	input wire logic transfer_acknowledge_oe,
	input wire host_port_pkg::byte_t data_out,
	output logic cs_n = 1'b1,
	output logic wr_pin = 1'b1,
	output logic rd_pin = 1'b1,
	output host_port_pkg::byte_t data_in = 8'h00
);
	import host_port_pkg::*;
	logic gen, fixed;
	assign gen = bus_style_select == `STYLE_GENERIC;
	// No handshake in styles 1 and 3: fixed cycle length
	assign fixed = bus_style_select[0];
	task automatic access(input logic rd, input logic sel, input byte_t d,
		output byte_t q, output logic ok);
		int n;
		@(posedge clk);
		cs_n <= !sel;
		wr_pin <= rd;
		rd_pin <= gen ? !rd : fixed;
		data_in <= d;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (n < 60 && (fixed || !sel ? n < 12 :
			!(transfer_acknowledge_oe && transfer_acknowledge == gen)));
		ok = n < 60;
		q = data_out;
		@(posedge clk);
		wr_pin <= 1'b1;
		rd_pin <= !fixed;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		data_in <= ~d;
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the host strobe port in every bus style.
// Assumes host_bus_model drives the pins; the core side lives here.
`timescale 1ns/10ps
`default_nettype none

`define CHK(what, exp, got) \
	n_compared++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("CHECK FAILED %s exp %h got %h", what, exp, got); \
	end

module testbench;
	import host_port_pkg::*;
	logic clk, cs_n, wr_pin, rd_pin, data_oe, ack, ack_oe, ok;
	logic sys_rst = 1'b1, core_wr_ready = 1'b0, core_rd_valid = 1'b0;
	logic core_wr_valid, core_rd_req, pend = 1'b0;
	logic [1:0] style = 2'h0;
	byte_t data_in, data_out, core_wr_data, q, last_wr, core_rd_data = 8'h00;
	int n_mismatch, n_compared, n_wr, n_rd, n_oe, cnt, lat;
	host_strobe_port host_strobe_port_i (.clk, .sys_rst, .cs_n, .wr_pin,
		.rd_pin, .bus_style_select(style), .data_in, .data_out, .data_oe,
		.transfer_acknowledge(ack), .transfer_acknowledge_oe(ack_oe),
		.core_wr_data, .core_wr_valid, .core_wr_ready, .core_rd_req,
		.core_rd_valid, .core_rd_data);
	host_bus_model host_bus_model_i (.clk, .bus_style_select(style),
		.transfer_acknowledge(ack), .transfer_acknowledge_oe(ack_oe),
		.data_out, .cs_n, .wr_pin, .rd_pin, .data_in);
	// ----------------------------------------
	// Core side: answers lat cycles into a select
	// ----------------------------------------
	always @(posedge clk) begin
		cnt <= cs_n ? 0 : cnt + 1;
		core_wr_ready <= cnt >= lat;
		pend <= core_rd_req | (pend & !core_rd_valid);
		core_rd_valid <= pend && !core_rd_valid && cnt >= lat;
		if (core_wr_valid === 1'b1) begin
			n_wr <= n_wr + 1;
			last_wr <= core_wr_data;
		end
		if (core_rd_req === 1'b1)
			n_rd <= n_rd + 1;
		if (data_oe === 1'b1)
			n_oe <= n_oe + 1;
	end
	task automatic set_style(input logic [1:0] s);
		@(posedge clk);
		style <= s;
		sys_rst <= 1'b1;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_write(input byte_t d, input int l);
		int w0;
		int o0;
		w0 = n_wr;
		o0 = n_oe;
		lat = l;
		host_bus_model_i.access(1'b0, 1'b1, d, q, ok);
		`CHK("write handshake", 1'b1, ok)
		`CHK("write count", w0 + 1, n_wr)
		`CHK("write data", d, last_wr)
		`CHK("write buffer off", o0, n_oe)
		`CHK("hold released", 1'b0, ack_oe)
	endtask
	task automatic t_read(input byte_t d, input int l);
		int r0;
		int o0;
		r0 = n_rd;
		o0 = n_oe;
		lat = l;
		@(posedge clk);
		core_rd_data <= d;
		host_bus_model_i.access(1'b1, 1'b1, 8'h00, q, ok);
		`CHK("read handshake", 1'b1, ok)
		`CHK("read data", d, q)
		`CHK("read count", r0 + 1, n_rd)
		`CHK("read buffer on", 1'b1, n_oe > o0)
		`CHK("read hold released", 1'b0, ack_oe)
	endtask
	task automatic t_none(input logic sel);
		int r0;
		int o0;
		r0 = n_rd;
		o0 = n_oe;
		host_bus_model_i.access(1'b1, sel, 8'h00, q, ok);
		`CHK("ignored read", r0, n_rd)
		`CHK("ignored buffer", o0, n_oe)
	endtask
	task automatic complete_run;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		n_mismatch++;
		complete_run;
	end
	initial begin
		for (int s = 0; s < 3; s++) begin
			set_style(2'(s));
			t_write(8'ha5, 0);
			t_write(8'h5a, 3);
			t_read(8'h3c, 4);
			t_read(8'hc3, 0);
			t_none(1'b0);
		end
		set_style(2'h3);
		t_none(1'b1);
		complete_run;
	end
endmodule
`default_nettype wire
